// file: design/adcpm_host.sv
// host end: runs conversion, power-down and wake frames on the serial link
// makes the serial clock by dividing the system clock; user holds a command until ready
`default_nettype none

module adcpm_host #(
   parameter int unsigned FULL_WAKE_CYCLES = adcpm_pkg::FULL_WAKE_CYCLES
) (
   // system clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // serial link
   adcpm_link_if.host link,
   // command
   input wire logic cmd_valid,
   input wire adcpm_pkg::adcpm_cmd_t cmd_kind,
   output logic cmd_ready,
   // results
   output logic [adcpm_pkg::WORD_W-1:0] data_first,
   output logic [adcpm_pkg::WORD_W-1:0] data_second,
   output logic data_valid,
   output logic busy
);
   typedef enum {
      H_IDLE,
      H_SETUP,
      H_LOW,
      H_HIGH,
      H_GAP
   } adcpm_hstate_t;

   adcpm_hstate_t st_q;
   logic cs_n_q;
   logic sclk_q;
   logic [3:0] ph_q;
   logic [5:0] falls_q;
   logic [5:0] len_q;
   logic conv_q;
   logic cut_q;
   logic [adcpm_pkg::TIMER_W-1:0] gap_q;
   logic cmd_ready_q;
   logic [11:0] sh_a_q;
   logic [11:0] sh_b_q;
   logic [11:0] data_first_q;
   logic [11:0] data_second_q;
   logic data_valid_q;
   logic busy_q;
   adcpm_pkg::adcpm_mode_t bmode_q;
   logic known_q;
   logic [adcpm_pkg::TIMER_W-1:0] dwell_q;
   logic first_s;
   logic second_s;
   logic need_wake;
   logic half_end;
   logic rise_now;
   logic frame_end;
   logic [adcpm_pkg::TIMER_W-1:0] wake_wait;

   adcpm_sync #(.INIT(1'b0)) u_first_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .d(link.first_line),
      .q(first_s)
   );

   adcpm_sync #(.INIT(1'b0)) u_second_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .d(link.second_line),
      .q(second_s)
   );

   // power-down from an unknown state needs a full cycle first
   always_comb begin
      if (cmd_kind == adcpm_pkg::ADCPM_CMD_POWER_DOWN) begin
         need_wake = !known_q;
      end else if (cmd_kind == adcpm_pkg::ADCPM_CMD_WAKE) begin
         need_wake = 1'b0;
      end else begin
         need_wake = !known_q || bmode_q != adcpm_pkg::ADCPM_NORMAL;
      end
   end

   // a short partial dwell does not earn the fast wake, so wait the long one
   always_comb begin
      if (known_q && bmode_q == adcpm_pkg::ADCPM_NORMAL) begin
         wake_wait = '0;
      end else if (known_q && bmode_q == adcpm_pkg::ADCPM_PARTIAL &&
                   dwell_q >= adcpm_pkg::TIMER_W'(adcpm_pkg::PARTIAL_DWELL_CYCLES)) begin
         wake_wait = adcpm_pkg::TIMER_W'(adcpm_pkg::PARTIAL_WAKE_CYCLES);
      end else begin
         wake_wait = adcpm_pkg::TIMER_W'(FULL_WAKE_CYCLES);
      end
   end

   assign half_end = ph_q == adcpm_pkg::SCLK_HALF - 4'h1;
   assign rise_now = st_q == H_LOW && half_end;
   assign frame_end = st_q == H_HIGH && half_end && falls_q == len_q;

   // frame sequencing: select, divided serial clock, gaps
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= H_IDLE;
         cs_n_q <= 1'b1;
         sclk_q <= 1'b1;
         ph_q <= 4'h0;
         falls_q <= 6'h00;
         len_q <= 6'h00;
         conv_q <= 1'b0;
         cut_q <= 1'b0;
         gap_q <= '0;
         cmd_ready_q <= 1'b0;
      end else begin
         cmd_ready_q <= 1'b0;
         ph_q <= half_end ? 4'h0 : ph_q + 4'h1;
         case (st_q)
            H_IDLE: begin
               ph_q <= 4'h0;
               falls_q <= 6'h00;
               if (cmd_valid) begin
                  st_q <= H_SETUP;
                  cs_n_q <= 1'b0;
                  cmd_ready_q <= !need_wake;
                  conv_q <= !need_wake && (cmd_kind == adcpm_pkg::ADCPM_CMD_CONVERT16 ||
                                           cmd_kind == adcpm_pkg::ADCPM_CMD_CONVERT32);
                  cut_q <= !need_wake && cmd_kind == adcpm_pkg::ADCPM_CMD_POWER_DOWN;
                  if (need_wake || cmd_kind == adcpm_pkg::ADCPM_CMD_CONVERT16 ||
                      cmd_kind == adcpm_pkg::ADCPM_CMD_WAKE) begin
                     len_q <= adcpm_pkg::WORD_FALLS;
                  end else if (cmd_kind == adcpm_pkg::ADCPM_CMD_CONVERT32) begin
                     len_q <= adcpm_pkg::TOTAL_FALLS;
                  end else begin
                     len_q <= adcpm_pkg::CUT_FALLS;
                  end
               end
            end
            H_SETUP, H_HIGH: begin
               if (frame_end) begin
                  st_q <= H_GAP;
                  cs_n_q <= 1'b1;
                  gap_q <= adcpm_pkg::TIMER_W'(adcpm_pkg::GAP_CYCLES) + (cut_q ? '0 : wake_wait);
               end else if (half_end) begin
                  st_q <= H_LOW;
                  sclk_q <= 1'b0;
                  falls_q <= falls_q + 6'h01;
               end
            end
            H_LOW: begin
               if (half_end) begin
                  st_q <= H_HIGH;
                  sclk_q <= 1'b1;
               end
            end
            H_GAP: begin
               if (gap_q == '0) begin
                  st_q <= H_IDLE;
               end else begin
                  gap_q <= gap_q - adcpm_pkg::TIMER_W'(1);
               end
            end
            default: begin
               st_q <= H_IDLE;
            end
         endcase
      end
   end

   // data is sampled at rising edges, half a period after the device shifts
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         sh_a_q <= 12'h000;
         sh_b_q <= 12'h000;
      end else if (rise_now) begin
         if (falls_q >= adcpm_pkg::FIRST_BIT_RISE && falls_q <= adcpm_pkg::LAST_BIT_RISE) begin
            sh_a_q <= {sh_a_q[10:0], first_s};
            if (len_q != adcpm_pkg::TOTAL_FALLS) begin
               sh_b_q <= {sh_b_q[10:0], second_s};
            end
         end else if (falls_q >= adcpm_pkg::FIRST_BIT_RISE + adcpm_pkg::WORD_FALLS &&
                      falls_q <= adcpm_pkg::LAST_BIT_RISE + adcpm_pkg::WORD_FALLS) begin
            sh_b_q <= {sh_b_q[10:0], first_s};
         end
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         data_first_q <= 12'h000;
         data_second_q <= 12'h000;
         data_valid_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         data_valid_q <= frame_end && conv_q;
         busy_q <= st_q != H_IDLE || cmd_valid;
         if (frame_end && conv_q) begin
            data_first_q <= sh_a_q;
            data_second_q <= sh_b_q;
         end
      end
   end

   // the host's own picture of the device's power mode
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         bmode_q <= adcpm_pkg::RESET_MODE;
         known_q <= 1'b0;
         dwell_q <= '0;
      end else if (frame_end) begin
         dwell_q <= '0;
         if (!cut_q) begin
            bmode_q <= adcpm_pkg::ADCPM_NORMAL;
            known_q <= 1'b1;
         end else if (bmode_q == adcpm_pkg::ADCPM_NORMAL) begin
            bmode_q <= adcpm_pkg::ADCPM_PARTIAL;
         end else begin
            bmode_q <= adcpm_pkg::ADCPM_FULL;
         end
      end else if (dwell_q != {adcpm_pkg::TIMER_W{1'b1}}) begin
         dwell_q <= dwell_q + adcpm_pkg::TIMER_W'(1);
      end
   end

   assign link.cs_n = cs_n_q;
   assign link.sclk = sclk_q;
   assign cmd_ready = cmd_ready_q;
   assign data_first = data_first_q;
   assign data_second = data_second_q;
   assign data_valid = data_valid_q;
   assign busy = busy_q;
endmodule

`default_nettype wire

// file: design/adcpm_pkg.sv
// constants and types shared by both ends of the power mode sequencer link
// assumes a 40 MHz system clock on both ends and a host-made serial clock
`default_nettype none

package adcpm_pkg;

   // serial frame layout, counted in serial-clock falling edges
   localparam int WORD_W = 12;
   localparam int CNT_W = 6;
   localparam logic [5:0] GLITCH_FALLS = 6'h02;
   localparam logic [5:0] KEEP_FALLS = 6'h0A;
   localparam logic [5:0] RESULT_FALLS = 6'h0E;
   localparam logic [5:0] WORD_FALLS = 6'h10;
   localparam logic [5:0] TOTAL_FALLS = 6'h20;
   localparam logic [5:0] CNT_MAX = 6'h21;
   localparam logic [5:0] CUT_FALLS = 6'h04;
   localparam logic [3:0] LEAD_ZEROS = 4'h2;
   localparam logic [3:0] LAST_DATA = 4'hD;
   // host reads a word at these rising edges
   localparam logic [5:0] FIRST_BIT_RISE = 6'h02;
   localparam logic [5:0] LAST_BIT_RISE = 6'h0D;

   // times in their own units
   localparam int unsigned CLOCK_PERIOD_NS = 25;
   localparam int unsigned PARTIAL_WAKE_NS = 1000;
   localparam int unsigned FULL_WAKE_NS = 1500000;
   localparam int unsigned PARTIAL_DWELL_NS = 67000;
   localparam int unsigned QUIET_INTERVAL_NS = 100;
   localparam int unsigned ACQ_TIME_NS = 100;

   // least times, rounded up to whole clock cycles
   function automatic int unsigned cycles_up(input int unsigned ns);
      return (ns + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   endfunction

   localparam int TIMER_W = 17;
   localparam int unsigned PARTIAL_WAKE_CYCLES = cycles_up(PARTIAL_WAKE_NS);
   localparam int unsigned FULL_WAKE_CYCLES = cycles_up(FULL_WAKE_NS);
   localparam int unsigned PARTIAL_DWELL_CYCLES = cycles_up(PARTIAL_DWELL_NS);
   localparam int unsigned GAP_CYCLES = cycles_up(QUIET_INTERVAL_NS) + cycles_up(ACQ_TIME_NS);
   // half period of the host-made serial clock, in system cycles
   localparam logic [3:0] SCLK_HALF = 4'h6;

   typedef enum logic [1:0] {
      ADCPM_NORMAL,
      ADCPM_PARTIAL,
      ADCPM_FULL
   } adcpm_mode_t;

   // supply-on mode is undefined; assume the deepest one
   localparam adcpm_mode_t RESET_MODE = ADCPM_FULL;

   typedef enum logic [1:0] {
      ADCPM_CMD_CONVERT16,
      ADCPM_CMD_CONVERT32,
      ADCPM_CMD_POWER_DOWN,
      ADCPM_CMD_WAKE
   } adcpm_cmd_t;

endpackage

`default_nettype wire

// file: design/adcpm_link_if.sv
// serial link between host and converter: chip select, serial clock, two data lines
// the host drives clock and select; undriven data lines read as zero (weak pull-down)
`default_nettype none

interface adcpm_link_if;
   logic sclk;
   logic cs_n;
   logic first_o;
   logic first_oe;
   logic second_o;
   logic second_oe;
   logic first_line;
   logic second_line;

   assign first_line = first_oe & first_o;
   assign second_line = second_oe & second_o;

   modport device(
      input sclk,
      input cs_n,
      output first_o,
      output first_oe,
      output second_o,
      output second_oe
   );

   modport host(
      output sclk,
      output cs_n,
      input first_line,
      input second_line
   );
endinterface

`default_nettype wire

// file: design/adcpm_sync.sv
// three-flop synchroniser; output moves once the second and third flops agree
// assumes the input level stands for at least three destination cycles
`default_nettype none

module adcpm_sync #(
   parameter logic INIT = 1'b0
) (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // level in and out
   input wire logic d,
   output logic q
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic q_q;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
         q_q <= INIT;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            q_q <= s3_q;
         end
      end
   end

   assign q = q_q;
endmodule

`default_nettype wire

// file: design/adcpm_device.sv
// converter end: power mode sequencer and serial result shifter
// link logic runs on the host's serial clock; mode logic runs on the system clock
// assumes result inputs are stable from chip select fall to the first serial-clock fall
//
// Functional notes
// - three modes, chosen by chip select rise
// - chip select fall samples, starts edge count
// - host holds select low ten falls
// - rise in falls 10..13 aborts, stays powered
// - fourteen clocks give a full result
// - output stays driven after fourteen falls
// - two trailing zeros follow each result
// - further clocks shift other result out
// - release at fall 32 or select rise
// - host waits quiet and acquisition time
// - normal: rise in falls 2..9 gives partial
// - rise before fall two keeps normal
// - partial: only reference stays powered
// - dummy cycle wakes partial in 1 us
// - partial glitch: power-up undone at rise
// - partial: rise in falls 2..9 gives full
// - full: everything powered down
// - host may skip clocks after cutting
// - full wake needs 1.5 ms from fall
// - partial dwell 67 us for short wake
// - supply-on mode unknown, run dummy first
// - two or three dummies reach power-down
// - two leading zeros then result, MSB first
`default_nettype none

module adcpm_device #(
   parameter int unsigned FULL_WAKE_CYCLES = adcpm_pkg::FULL_WAKE_CYCLES
) (
   // system clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // serial link
   adcpm_link_if.device link,
   // results of the two converter cores
   input wire logic [adcpm_pkg::WORD_W-1:0] result_a,
   input wire logic [adcpm_pkg::WORD_W-1:0] result_b,
   // power state
   output var adcpm_pkg::adcpm_mode_t mode,
   output logic analog_on,
   output logic ref_on,
   output logic ready,
   output logic conv_done
);
   // serial word bit for frame position pos (1 = level shown at select fall)
   function automatic logic frame_bit(input logic [5:0] pos, input logic [11:0] w1,
                                      input logic [11:0] w2);
      logic [5:0] idx;
      logic [3:0] off;
      logic [11:0] word;
      idx = pos - 6'h01;
      off = idx[3:0];
      word = idx[4] ? w2 : w1;
      if (off < adcpm_pkg::LEAD_ZEROS || off > adcpm_pkg::LAST_DATA) begin
         frame_bit = 1'b0;
      end else begin
         frame_bit = word[4'(adcpm_pkg::LAST_DATA - off)];
      end
   endfunction

   // link domain
   logic frame_clr;
   logic frame_tgl_q;
   logic cnt_tgl_q;
   logic [5:0] cnt_q;
   logic [5:0] cnt_nx;
   logic [11:0] a_q;
   logic [11:0] b_q;
   logic oe_q;
   logic first_q;
   logic second_q;
   logic done_tgl_q;

   // select high, or reset, releases both lines at once
   assign frame_clr = sys_rst | link.cs_n;

   // a new frame is marked by toggling on the select fall itself
   always_ff @(negedge link.cs_n or posedge sys_rst) begin
      if (sys_rst) begin
         frame_tgl_q <= 1'b0;
      end else begin
         frame_tgl_q <= ~frame_tgl_q;
      end
   end

   // first fall of a new frame restarts the count at one
   always_comb begin
      if (cnt_tgl_q != frame_tgl_q) begin
         cnt_nx = 6'h01;
      end else if (cnt_q == adcpm_pkg::CNT_MAX) begin
         cnt_nx = cnt_q;
      end else begin
         cnt_nx = cnt_q + 6'h01;
      end
   end

   always_ff @(negedge link.sclk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= 6'h00;
         cnt_tgl_q <= 1'b0;
      end else if (!link.cs_n) begin
         cnt_q <= cnt_nx;
         cnt_tgl_q <= frame_tgl_q;
      end
   end

   // results are frozen at the first fall; the core holds them since select fell
   always_ff @(negedge link.sclk or posedge sys_rst) begin
      if (sys_rst) begin
         a_q <= 12'h000;
         b_q <= 12'h000;
      end else if (!link.cs_n && cnt_nx == 6'h01) begin
         a_q <= result_a;
         b_q <= result_b;
      end
   end

   // line a sends a then b, line b sends b then a
   always_ff @(negedge link.sclk or posedge frame_clr) begin
      if (frame_clr) begin
         oe_q <= 1'b0;
         first_q <= 1'b0;
         second_q <= 1'b0;
      end else begin
         oe_q <= cnt_nx < adcpm_pkg::TOTAL_FALLS;
         first_q <= frame_bit(cnt_nx + 6'h01, a_q, b_q);
         second_q <= frame_bit(cnt_nx + 6'h01, b_q, a_q);
      end
   end

   always_ff @(negedge link.sclk or posedge sys_rst) begin
      if (sys_rst) begin
         done_tgl_q <= 1'b0;
      end else if (!link.cs_n && cnt_nx == adcpm_pkg::RESULT_FALLS && cnt_q != cnt_nx) begin
         done_tgl_q <= ~done_tgl_q;
      end
   end

   assign link.first_o = first_q;
   assign link.second_o = second_q;
   assign link.first_oe = oe_q;
   assign link.second_oe = oe_q;

   // system domain
   logic cs_s;
   logic cs_prev_q;
   logic cs_fall;
   logic cs_rise;
   logic done_s;
   logic done_prev_q;
   logic [5:0] falls;
   adcpm_pkg::adcpm_mode_t mode_q;
   logic waking_q;
   logic [adcpm_pkg::TIMER_W-1:0] wake_q;
   logic analog_on_q;
   logic ref_on_q;
   logic ready_q;
   logic conv_done_q;

   adcpm_sync #(.INIT(1'b1)) u_cs_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .d(link.cs_n),
      .q(cs_s)
   );

   adcpm_sync #(.INIT(1'b0)) u_done_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .d(done_tgl_q),
      .q(done_s)
   );

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         cs_prev_q <= 1'b1;
         done_prev_q <= 1'b0;
      end else begin
         cs_prev_q <= cs_s;
         done_prev_q <= done_s;
      end
   end

   assign cs_fall = cs_prev_q & ~cs_s;
   assign cs_rise = ~cs_prev_q & cs_s;

   // the count is frozen while select is high, so it is safe to read here;
   // a frame with no fall at all still carries the old toggle and counts zero
   assign falls = (cnt_tgl_q == frame_tgl_q) ? cnt_q : 6'h00;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         mode_q <= adcpm_pkg::RESET_MODE;
      end else if (cs_rise) begin
         if (falls >= adcpm_pkg::KEEP_FALLS) begin
            mode_q <= adcpm_pkg::ADCPM_NORMAL;
         end else if (falls >= adcpm_pkg::GLITCH_FALLS) begin
            case (mode_q)
               adcpm_pkg::ADCPM_NORMAL: begin
                  mode_q <= adcpm_pkg::ADCPM_PARTIAL;
               end
               adcpm_pkg::ADCPM_PARTIAL: begin
                  mode_q <= adcpm_pkg::ADCPM_FULL;
               end
               default: begin
                  mode_q <= adcpm_pkg::ADCPM_FULL;
               end
            endcase
         end
         // fewer than two falls: mode kept
      end
   end

   // power-up starts at the fall and is undone by an early rise
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         waking_q <= 1'b0;
         wake_q <= '0;
      end else if (cs_fall && mode_q != adcpm_pkg::ADCPM_NORMAL) begin
         waking_q <= 1'b1;
         if (mode_q == adcpm_pkg::ADCPM_PARTIAL) begin
            wake_q <= adcpm_pkg::TIMER_W'(adcpm_pkg::PARTIAL_WAKE_CYCLES);
         end else begin
            wake_q <= adcpm_pkg::TIMER_W'(FULL_WAKE_CYCLES);
         end
      end else if (cs_rise && falls < adcpm_pkg::KEEP_FALLS) begin
         waking_q <= 1'b0;
         wake_q <= '0;
      end else if (wake_q > adcpm_pkg::TIMER_W'(1)) begin
         wake_q <= wake_q - adcpm_pkg::TIMER_W'(1);
      end else begin
         wake_q <= '0;
         waking_q <= waking_q && mode_q != adcpm_pkg::ADCPM_NORMAL;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         analog_on_q <= 1'b0;
         ref_on_q <= 1'b0;
         ready_q <= 1'b0;
      end else begin
         analog_on_q <= mode_q == adcpm_pkg::ADCPM_NORMAL || waking_q;
         ref_on_q <= mode_q != adcpm_pkg::ADCPM_FULL || waking_q;
         ready_q <= mode_q == adcpm_pkg::ADCPM_NORMAL && !waking_q;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         conv_done_q <= 1'b0;
      end else begin
         conv_done_q <= done_s ^ done_prev_q;
      end
   end

   assign mode = mode_q;
   assign analog_on = analog_on_q;
   assign ref_on = ref_on_q;
   assign ready = ready_q;
   assign conv_done = conv_done_q;
endmodule

`default_nettype wire

// file: verification/adcpm_link_chk.sv
// link checker: frame edge count, drive windows, serial word zeros, power modes
// assumes the system clock samples the host-made serial clock several times per half period
`default_nettype none

module adcpm_link_chk (
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic first_o,
   input wire logic first_oe,
   input wire logic second_o,
   input wire logic second_oe,
   // power state
   input wire adcpm_pkg::adcpm_mode_t mode,
   input wire logic analog_on,
   input wire logic ref_on
);
   logic sclk_q;
   logic [5:0] cnt_q;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) sclk_q <= 1'h1;
      else sclk_q <= sclk;
   end

   // saturates like the device, so late falls never wrap into the drive window
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) cnt_q <= 6'h00;
      else if (cs_n) cnt_q <= 6'h00;
      else if (sclk_q && !sclk && cnt_q != 6'h21) cnt_q <= cnt_q + 6'h01;
   end

   a_cut_release: assert property (cs_n |-> !first_oe && !second_oe)
      else $error("data line driven with select high");
   a_drive_window: assert property (!cs_n && sclk && cnt_q inside {[6'h01:6'h1F]}
      |-> first_oe && second_oe)
      else $error("data line released inside frame");
   a_release_last: assert property (cnt_q >= 6'h20 |-> !first_oe && !second_oe)
      else $error("data line driven after last fall");
   a_lead_zero: assert property (sclk && cnt_q == 6'h01 |-> !first_o && !second_o)
      else $error("second leading bit not zero");
   a_trail_zero: assert property (sclk && !cs_n && cnt_q inside {6'h0E, 6'h0F, 6'h1E, 6'h1F}
      |-> !first_o && !second_o)
      else $error("trailing bit not zero");
   a_keep_normal: assert property ($rose(cs_n) && cnt_q >= 6'h0A
      |-> ##[1:6] mode == adcpm_pkg::ADCPM_NORMAL)
      else $error("long frame did not give normal mode");
   a_enter_partial: assert property ($rose(cs_n) && cnt_q inside {[6'h02:6'h09]}
      && mode == adcpm_pkg::ADCPM_NORMAL |-> ##[1:6] mode == adcpm_pkg::ADCPM_PARTIAL)
      else $error("cut frame did not give partial mode");
   a_enter_full: assert property ($rose(cs_n) && cnt_q inside {[6'h02:6'h09]}
      && mode == adcpm_pkg::ADCPM_PARTIAL |-> ##[1:6] mode == adcpm_pkg::ADCPM_FULL)
      else $error("cut frame did not give full mode");
   a_partial_power: assert property (cs_n [*8] ##0 mode == adcpm_pkg::ADCPM_PARTIAL
      |-> ref_on && !analog_on)
      else $error("partial mode power wrong");
   a_full_power: assert property (cs_n [*8] ##0 mode == adcpm_pkg::ADCPM_FULL
      |-> !ref_on && !analog_on)
      else $error("full mode power wrong");
endmodule

`default_nettype wire

// file: verification/test_adc_power_mode_sequencer.sv
// bench: host and device joined on one link; random results and commands
// assumes the host makes the serial clock; full wake time shortened by parameter
`default_nettype none

module test_adc_power_mode_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned WAKE = 200;
   logic clock = 1'h0;
   logic sys_rst = 1'h1;
   logic cmd_valid = 1'h0;
   adcpm_pkg::adcpm_cmd_t cmd_kind = adcpm_pkg::ADCPM_CMD_WAKE;
   logic cmd_ready, data_valid, busy, analog_on, ref_on, ready, conv_done;
   logic [11:0] result_a = 12'h000;
   logic [11:0] result_b = 12'h000;
   logic [11:0] data_first, data_second;
   logic [31:0] sh1, sh2, seed;
   int rises;
   adcpm_pkg::adcpm_mode_t mode;
   adcpm_pkg::adcpm_mode_t exp_mode = adcpm_pkg::ADCPM_NORMAL;
   int fail_count = 0;
   int tests_run = 0;
   adcpm_pkg::adcpm_cmd_t plan [9] = '{adcpm_pkg::ADCPM_CMD_CONVERT16, adcpm_pkg::ADCPM_CMD_CONVERT32,
      adcpm_pkg::ADCPM_CMD_POWER_DOWN, adcpm_pkg::ADCPM_CMD_POWER_DOWN, adcpm_pkg::ADCPM_CMD_POWER_DOWN,
      adcpm_pkg::ADCPM_CMD_CONVERT16, adcpm_pkg::ADCPM_CMD_POWER_DOWN, adcpm_pkg::ADCPM_CMD_WAKE,
      adcpm_pkg::ADCPM_CMD_CONVERT32};

   adcpm_link_if link();
   adcpm_host #(.FULL_WAKE_CYCLES(WAKE)) i_adcpm_host (.clock(clock), .sys_rst(sys_rst), .link(link),
      .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_ready(cmd_ready), .data_first(data_first),
      .data_second(data_second), .data_valid(data_valid), .busy(busy));
   adcpm_device #(.FULL_WAKE_CYCLES(WAKE)) i_adcpm_device (.clock(clock), .sys_rst(sys_rst), .link(link),
      .result_a(result_a), .result_b(result_b), .mode(mode), .analog_on(analog_on), .ref_on(ref_on),
      .ready(ready), .conv_done(conv_done));
   adcpm_link_chk i_adcpm_link_chk (.clock(clock), .sys_rst(sys_rst), .sclk(link.sclk), .cs_n(link.cs_n),
      .first_o(link.first_o), .first_oe(link.first_oe), .second_o(link.second_o), .second_oe(link.second_oe),
      .mode(mode), .analog_on(analog_on), .ref_on(ref_on));

   initial forever #12.5 clock = ~clock;

   // wire capture at the host's sampling edge
   always @(negedge link.cs_n) begin
      sh1 = 32'h0;
      sh2 = 32'h0;
      rises = 0;
   end
   always @(posedge link.sclk) begin
      if (!link.cs_n) begin
         sh1 = {sh1[30:0], link.first_line};
         sh2 = {sh2[30:0], link.second_line};
         rises++;
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // one 16-position word as sampled from the second position on
   function automatic logic [15:0] half(input logic [11:0] w);
      return {1'h0, w, 3'h0};
   endfunction

   function automatic adcpm_pkg::adcpm_mode_t deeper(input adcpm_pkg::adcpm_mode_t m);
      return (m == adcpm_pkg::ADCPM_NORMAL) ? adcpm_pkg::ADCPM_PARTIAL : adcpm_pkg::ADCPM_FULL;
   endfunction

   task automatic check(input logic ok, input string what);
      tests_run++;
      if (ok !== 1'h1) begin
         fail_count++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask

   task automatic run(input adcpm_pkg::adcpm_cmd_t k);
      int n;
      logic dv;
      logic cd;
      dv = 1'h0;
      cd = 1'h0;
      seed = lfsr(seed);
      @(posedge clock);
      result_a <= seed[11:0];
      result_b <= seed[27:16];
      cmd_valid <= 1'h1;
      cmd_kind <= k;
      for (n = 0; n < 20000 && cmd_ready !== 1'h1; n++) @(posedge clock);
      check(cmd_ready === 1'h1, "command taken");
      cmd_valid <= 1'h0;
      for (n = 0; n < 20000 && busy !== 1'h0; n++) begin
         @(posedge clock);
         dv = dv | (data_valid === 1'h1);
         cd = cd | (conv_done === 1'h1);
      end
      check(busy === 1'h0, "frame and gap ended");
      check(cd === (k != adcpm_pkg::ADCPM_CMD_POWER_DOWN), "conversion done");
      if (k == adcpm_pkg::ADCPM_CMD_CONVERT16) begin
         check(data_first === result_a && data_second === result_b, "two-line result");
         check({sh1[15:0], sh2[15:0]} === {half(result_a), half(result_b)}, "16 wire words");
         check(rises == 16, "16 clocks");
      end
      if (k == adcpm_pkg::ADCPM_CMD_CONVERT32) begin
         check(data_first === result_a && data_second === result_b, "one-line result");
         check({sh1, sh2} === {half(result_a), half(result_b), half(result_b), half(result_a)},
            "32 words");
      end
      if (k == adcpm_pkg::ADCPM_CMD_POWER_DOWN) exp_mode = deeper(exp_mode);
      else exp_mode = adcpm_pkg::ADCPM_NORMAL;
      if (k != adcpm_pkg::ADCPM_CMD_POWER_DOWN && k != adcpm_pkg::ADCPM_CMD_WAKE) begin
         check(dv && ready === 1'h1, "ready after conversion");
      end
      check(mode === exp_mode, "mode");
      check(ref_on === (exp_mode != adcpm_pkg::ADCPM_FULL), "reference power");
      check(analog_on === (exp_mode == adcpm_pkg::ADCPM_NORMAL), "analog power");
   endtask

   task automatic conclude();
      $display("checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      seed = 32'h000021E6;
      repeat (8) @(posedge clock);
      sys_rst <= 1'h0;
      foreach (plan[i]) run(plan[i]);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         run(adcpm_pkg::adcpm_cmd_t'(seed[1:0]));
      end
      conclude();
   end

   initial begin
      #2000000;
      fail_count++;
      $display("unexpected at %0t: timeout", $time);
      conclude();
   end
endmodule

`default_nettype wire
